// >>> pfcm_defs.vh
/*
  constants for the parallel flash configuration loader: mode codes,
  address start values and configuration clock divider.
  assumes inclusion by bare name from the design files.
*/
`ifndef PFCM_DEFS_VH
`define PFCM_DEFS_VH
`define PFCM_ADDR_W        24
`define PFCM_DATA_W        8
`define PFCM_MODE_W        3
`define PFCM_MODE_HI_BPI   2'h1
`define PFCM_ADDR_ZERO     24'h000000
`define PFCM_ADDR_ONES     24'hffffff
`define PFCM_CLK_HALF      4
`define PFCM_PERSIST_HI    4
`endif

// >>> pfcm_sync2.v
/*
  two-flop synchroniser, parameterised width.
  assumes inputs come from outside the core_clk_i domain.
*/
`timescale 1ns/100ps
module pfcm_sync2 #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         rst_n_i,
  input  wire         clk_en_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] stage1;
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stage1 <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else if (clk_en_i) begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // pfcm_sync2

// >>> pfcm_loader.v
/*
  parallel flash configuration master: generates the configuration clock,
  walks a 24-bit flash address, captures bytes and drives the fixed strobes
  and pin-ownership flags during and after configuration.
  assumes mode, pull-up control and flash data arrive from pins; start,
  keep-port option and done come from logic on core_clk_i.
  the configuration clock is core_clk_i divided by twice CLK_HALF; the flash
  must answer within one half period less the two synchroniser cycles.
  only a reset starts a second load; done is ignored outside a load.
  clk_en_i low freezes every register, the synchroniser included.
*/
// Overview of operation
// - pull-ups on all user pins while configuring when pull-up control is 0.
// - after done rises, pull-up control pin becomes user I/O.
// - chip-select output and configuration clock output driven throughout configuration.
// - busy output driven during configuration, user I/O afterwards.
// - after configuration all interface pins except done and program become user I/O.
// - keep-port option keeps slave parallel port active after configuration.
// - keep-port option also keeps four top address outputs as configuration pins.
// - mode 2:1 = 0,1 selects flash; bit 0 picks up-from-zero or down-from-ones.
// - mode inputs sampled when initialization status output rises.
// - flash chip-enable driven low throughout configuration.
// - flash output-enable driven low throughout configuration.
// - flash write-enable driven high throughout configuration.
// - flash byte-mode driven low throughout configuration.
// - new address presented on falling configuration clock edge.
// - flash byte captured on rising configuration clock edge.
`timescale 1ns/100ps
`include "pfcm_defs.vh"
module pfcm_loader #(
  parameter AW       = `PFCM_ADDR_W,
  parameter DW       = `PFCM_DATA_W,
  parameter CLK_HALF = `PFCM_CLK_HALF
) (
  input  wire          core_clk_i,
  input  wire          rst_n_i,
  input  wire          clk_en_i,
  input  wire          init_release_i,
  input  wire          done_i,
  input  wire          keep_port_i,
  input  wire [2:0]    mode_pin_i,
  input  wire          pullup_disable_ctl_i,
  input  wire          rd_wr_ctl_n_i,
  input  wire          chip_sel_in_n_i,
  input  wire [DW-1:0] flash_data_i,
  output reg           init_status_o,
  output reg           bpi_mode_o,
  output reg           addr_dir_sel_o,
  output reg           configuring_o,
  output reg  [AW-1:0] flash_addr_o,
  output reg           addr_oe_o,
  output reg  [3:0]    addr_top_oe_o,
  output reg           prom_ce_n_o,
  output reg           prom_oe_n_o,
  output reg           prom_we_n_o,
  output reg           prom_byte_n_o,
  output reg           strobe_oe_o,
  output reg           cfg_clk_out_o,
  output reg           cfg_clk_oe_o,
  output reg           chip_sel_out_n_o,
  output reg           chip_sel_oe_o,
  output reg           busy_o,
  output reg           busy_oe_o,
  output reg           pullup_en_o,
  output reg           pullup_ctl_user_o,
  output reg           port_persist_o,
  output reg           host_ctl_err_o,
  output reg  [DW-1:0] cfg_byte_o,
  output reg           cfg_byte_vld_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam CW      = 8;
  // last divider count of a half period
  localparam [CW-1:0] HALF_LAST       = CLK_HALF[CW-1:0] - 8'h01;
  localparam [AW-1:0] ADDR_FIRST_UP   = `PFCM_ADDR_ZERO;
  localparam [AW-1:0] ADDR_FIRST_DOWN = `PFCM_ADDR_ONES;

  wire [2:0]    mode_s;
  wire          pull_s;
  wire          rdwr_s;
  wire          csi_s;
  wire [DW-1:0] data_s;

  // pins cross into the core clock domain; only the second flop is read
  pfcm_sync2 #(.W(DW + 6)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .async_i    ({mode_pin_i, pullup_disable_ctl_i, rd_wr_ctl_n_i, chip_sel_in_n_i, flash_data_i}),
    .sync_o     ({mode_s, pull_s, rdwr_s, csi_s, data_s})
  );

  reg [1:0]    state;
  reg [1:0]    next_state;
  reg [CW-1:0] div_cnt;
  reg          dir_down;

  wire half_tick = (div_cnt == HALF_LAST);

  // one step of the address walk, wrapping at either end
  wire [AW-1:0] addr_up   = flash_addr_o + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] addr_down = flash_addr_o - {{(AW-1){1'b0}}, 1'b1};

  // sequencer: idle until init release, load until done, then rest until reset
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (init_release_i) next_state = ST_LOAD;
      ST_LOAD: if (done_i) next_state = ST_DONE;
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_IDLE;
    endcase
  end

  // every output is a register of this bank
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state             <= ST_IDLE;
      div_cnt           <= 8'h00;
      dir_down          <= 1'b0;
      init_status_o     <= 1'b0;
      bpi_mode_o        <= 1'b0;
      addr_dir_sel_o    <= 1'b0;
      configuring_o     <= 1'b0;
      flash_addr_o      <= ADDR_FIRST_UP;
      addr_oe_o         <= 1'b0;
      addr_top_oe_o     <= 4'h0;
      prom_ce_n_o       <= 1'b1;
      prom_oe_n_o       <= 1'b1;
      prom_we_n_o       <= 1'b1;
      prom_byte_n_o     <= 1'b0;
      strobe_oe_o       <= 1'b0;
      cfg_clk_out_o     <= 1'b0;
      cfg_clk_oe_o      <= 1'b0;
      chip_sel_out_n_o  <= 1'b1;
      chip_sel_oe_o     <= 1'b0;
      busy_o            <= 1'b0;
      busy_oe_o         <= 1'b0;
      pullup_en_o       <= 1'b0;
      pullup_ctl_user_o <= 1'b0;
      port_persist_o    <= 1'b0;
      host_ctl_err_o    <= 1'b0;
      cfg_byte_o        <= 8'h00;
      cfg_byte_vld_o    <= 1'b0;
    end else if (clk_en_i) begin
      state          <= next_state;
      cfg_byte_vld_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          // pull-up choice follows the pin until the load starts, then holds
          pullup_en_o <= ~pull_s;
          if (init_release_i) begin
            // mode and direction are taken once, as init status rises
            init_status_o  <= 1'b1;
            bpi_mode_o     <= (mode_s[2:1] == `PFCM_MODE_HI_BPI);
            addr_dir_sel_o <= mode_s[0];
            dir_down       <= mode_s[0];
            flash_addr_o   <= mode_s[0] ? ADDR_FIRST_DOWN : ADDR_FIRST_UP;
            configuring_o  <= 1'b1;
            addr_oe_o      <= 1'b1;
            addr_top_oe_o  <= 4'hf;
            strobe_oe_o    <= 1'b1;
            prom_ce_n_o    <= 1'b0;
            prom_oe_n_o    <= 1'b0;
            prom_we_n_o    <= 1'b1;
            prom_byte_n_o  <= 1'b0;
            cfg_clk_oe_o   <= 1'b1;
            chip_sel_oe_o  <= 1'b1;
            chip_sel_out_n_o <= 1'b1;
            busy_oe_o      <= 1'b1;
            busy_o         <= 1'b0;
          end
        end
        ST_LOAD: begin
          // host strobes must stay low while loading
          if (rdwr_s | csi_s)
            host_ctl_err_o <= 1'b1;
          if (done_i) begin
            // hand every interface pin not held by the kept port back to user logic
            configuring_o     <= 1'b0;
            pullup_en_o       <= 1'b0;
            pullup_ctl_user_o <= 1'b1;
            busy_oe_o         <= 1'b0;
            // the kept port holds its clock pin and the top address lines
            cfg_clk_oe_o      <= keep_port_i;
            chip_sel_oe_o     <= 1'b0;
            strobe_oe_o       <= 1'b0;
            addr_oe_o         <= 1'b0;
            addr_top_oe_o     <= {4{keep_port_i}};
            port_persist_o    <= keep_port_i;
            div_cnt           <= 8'h00;
          end else if (half_tick) begin
            div_cnt       <= 8'h00;
            cfg_clk_out_o <= ~cfg_clk_out_o;
            if (cfg_clk_out_o) begin
              // falling edge: step address
              flash_addr_o <= dir_down ? addr_down : addr_up;
            end else begin
              // rising edge: take the byte
              cfg_byte_o     <= data_s;
              cfg_byte_vld_o <= 1'b1;
            end
          end else begin
            div_cnt <= div_cnt + 8'h01;
          end
        end
        ST_DONE: begin
          // clock parks low; a new load needs a reset
          cfg_clk_out_o <= 1'b0;
        end
        default: begin
          configuring_o <= 1'b0;
        end
      endcase
    end
  end
endmodule // pfcm_loader

// >>> pfcm_loader_assertions.sv
/* checker on the loader ports: strobe levels, address walk, release after done.
   assumes bind onto pfcm_loader, clock enable high, pins held steady while loading */
`timescale 1ns/100ps
module pfcm_loader_assertions (
  input wire logic        core_clk_i, rst_n_i, done_i, keep_port_i, pullup_disable_ctl_i,
  input wire logic [2:0]  mode_pin_i,
  input wire logic        init_status_o, bpi_mode_o, addr_dir_sel_o, configuring_o, addr_oe_o,
  input wire logic [23:0] flash_addr_o,
  input wire logic [3:0]  addr_top_oe_o,
  input wire logic        prom_ce_n_o, prom_oe_n_o, prom_we_n_o, prom_byte_n_o, strobe_oe_o, cfg_clk_out_o,
  input wire logic        cfg_clk_oe_o, chip_sel_oe_o, busy_oe_o, pullup_en_o, pullup_ctl_user_o,
  input wire logic        port_persist_o, cfg_byte_vld_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ce_low: assert property (configuring_o |-> !prom_ce_n_o && strobe_oe_o) else $error("ce not low");
  a_oe_low: assert property (configuring_o |-> !prom_oe_n_o) else $error("oe not low");
  a_we_byte: assert property (configuring_o |-> prom_we_n_o && !prom_byte_n_o) else $error("we/byte");
  a_pins_driven: assert property (configuring_o |-> cfg_clk_oe_o && chip_sel_oe_o && busy_oe_o)
    else $error("pin not driven");
  a_pullup_sel: assert property (configuring_o |-> pullup_en_o == !pullup_disable_ctl_i)
    else $error("pull-up wrong");
  a_mode_take: assert property ($rose(init_status_o) |-> bpi_mode_o == (mode_pin_i[2:1] == 2'b01)
    && addr_dir_sel_o == mode_pin_i[0] && flash_addr_o == {24{mode_pin_i[0]}}) else $error("mode");
  a_addr_step: assert property ($fell(cfg_clk_out_o) && configuring_o |-> flash_addr_o ==
    $past(flash_addr_o) + (addr_dir_sel_o ? 24'hffffff : 24'h1)) else $error("address step");
  a_addr_hold: assert property (configuring_o && $past(configuring_o) && !$fell(cfg_clk_out_o)
    |-> $stable(flash_addr_o)) else $error("address moved");
  a_byte_rise: assert property ($rose(cfg_clk_out_o) |-> cfg_byte_vld_o) else $error("no capture");
  a_done_free: assert property (done_i && configuring_o |=> !configuring_o && !addr_oe_o && pullup_ctl_user_o
    && port_persist_o == $past(keep_port_i) && addr_top_oe_o == {4{$past(keep_port_i)}})
    else $error("release after done");
  cover property ($rose(configuring_o) && addr_dir_sel_o);
  cover property (done_i && configuring_o && keep_port_i);
  cover property (cfg_byte_vld_o);
endmodule // pfcm_loader_assertions
bind pfcm_loader pfcm_loader_assertions i_pfcm_loader_assertions (.*);

// >>> pfcm_flash_model.sv
/* behavioural asynchronous flash: byte derived from the address.
   assumes a released bus flips its last value */
`timescale 1ns/100ps
module pfcm_flash_model (
  input  wire logic [23:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  output logic      [7:0]  data_o
);
  initial data_o = 8'h5a;
  always @(addr_i or ce_n_i or oe_n_i or we_n_i)
    if (!ce_n_i && !oe_n_i && we_n_i) data_o <= #3 addr_i[7:0] ^ addr_i[23:16];
    else data_o <= #3 ~data_o;
endmodule // pfcm_flash_model

// >>> tb_top.sv
/* self-checking bench: loader with the flash model on its pins.
   assumes the default configuration clock divider */
`timescale 1ns/100ps
module tb_top;
  logic core_clk_i = 0, rst_n_i = 0, clk_en_i = 1, init_release_i = 0, done_i = 0, keep_port_i = 0;
  logic [2:0] mode_pin_i = 3'h2;
  logic pullup_disable_ctl_i = 0, rd_wr_ctl_n_i = 0, chip_sel_in_n_i = 0;
  wire [7:0] flash_data_i, cfg_byte_o;
  wire [23:0] flash_addr_o;
  wire [3:0] addr_top_oe_o;
  wire init_status_o, bpi_mode_o, addr_dir_sel_o, configuring_o, addr_oe_o, prom_ce_n_o, prom_oe_n_o, prom_we_n_o,
       prom_byte_n_o, strobe_oe_o, cfg_clk_out_o, cfg_clk_oe_o, chip_sel_out_n_o, chip_sel_oe_o, busy_o, busy_oe_o,
       pullup_en_o, pullup_ctl_user_o, port_persist_o, host_ctl_err_o, cfg_byte_vld_o;
  int fail_count = 0, n_compared = 0, cycles = 0;
  pfcm_loader i_pfcm_loader (.*);
  // user logic holds the flash deselected once the strobes are released
  pfcm_flash_model i_pfcm_flash_model (.addr_i(flash_addr_o), .ce_n_i(strobe_oe_o ? prom_ce_n_o : 1'b1),
    .oe_n_i(prom_oe_n_o), .we_n_i(prom_we_n_o), .data_o(flash_data_i));
  always #5 core_clk_i = ~core_clk_i;
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic t_load(input logic [2:0] mode, input logic keep, input logic pu, input int nbytes);
    logic [23:0] addr;
    int k;
    addr = {24{mode[0]}};
    rst_n_i = 0;
    mode_pin_i = mode;
    pullup_disable_ctl_i = pu;
    keep_port_i = keep;
    step(4);
    rst_n_i = 1;
    step(3);
    init_release_i = 1;
    step(1);
    init_release_i = 0;
    step(1);
    chk("bpi_mode", 24'(mode[2:1] == 2'b01), 24'(bpi_mode_o));
    chk("mode_taken", 24'({1'b1, mode[0]}), 24'({init_status_o, addr_dir_sel_o}));
    chk("pullup_en", 24'(!pu), 24'(pullup_en_o));
    chk("strobes", 24'h17, 24'({prom_ce_n_o, prom_oe_n_o, prom_we_n_o, prom_byte_n_o, cfg_clk_oe_o,
      chip_sel_oe_o, busy_oe_o}));
    for (int b = 0; b < nbytes; b++) begin
      for (k = 0; k < 20 && cfg_byte_vld_o !== 1'b1; k++) step(1);
      chk("flash_addr", addr, flash_addr_o);
      chk("cfg_byte", 24'(addr[7:0] ^ addr[23:16]), 24'(cfg_byte_o));
      addr = mode[0] ? addr - 24'h1 : addr + 24'h1;
      step(1);
    end
    done_i = 1;
    step(1);
    done_i = 0;
    step(1);
    chk("after_done", 24'({4'h1, keep, {4{keep}}}), 24'({configuring_o, busy_oe_o, addr_oe_o,
      pullup_ctl_user_o, port_persist_o, addr_top_oe_o}));
    chk("host_side", 24'h2, 24'({host_ctl_err_o, chip_sel_out_n_o, busy_o}));
    $display("load with mode %b keep %b done", mode, keep);
  endtask
  task automatic t_fault_freeze;
    logic [23:0] held;
    logic hclk;
    rst_n_i = 0;
    mode_pin_i = 3'h2;
    pullup_disable_ctl_i = 0;
    step(4);
    rst_n_i = 1;
    step(3);
    init_release_i = 1;
    step(1);
    init_release_i = 0;
    step(5);
    held = flash_addr_o;
    hclk = cfg_clk_out_o;
    clk_en_i = 0;
    step(12);
    chk("frozen_addr", held, flash_addr_o);
    chk("frozen_clk", 24'(hclk), 24'(cfg_clk_out_o));
    clk_en_i = 1;
    rd_wr_ctl_n_i = 1;
    step(4);
    rd_wr_ctl_n_i = 0;
    step(4);
    chk("host_ctl_err", 24'h1, 24'(host_ctl_err_o));
    done_i = 1;
    step(1);
    done_i = 0;
    step(1);
    chk("host_ctl_err_held", 24'h1, 24'(host_ctl_err_o));
    $display("fault and freeze done");
  endtask
  initial begin
    step(12);
    t_load(3'h2, 1'b0, 1'b0, 3);
    t_load(3'h3, 1'b1, 1'b1, 3);
    t_load(3'h4, 1'b0, 1'b0, 0);
    t_fault_freeze();
    complete_run();
  end
endmodule // tb_top
